// ### rtl/sfifo_pkg.sv
// Constants, carriers and state layout of the streaming FIFO
package sfifo_pkg;

    // ****************************************
    // Widths and depths
    // ****************************************
    localparam int BITS_PER_SYMBOL  = 8;
    localparam int SYMBOLS_PER_BEAT = 4;
    localparam int DATA_W           = BITS_PER_SYMBOL * SYMBOLS_PER_BEAT;
    localparam int ERROR_W          = 1;
    localparam int CHANNEL_W        = 8;
    localparam int MAX_CHANNEL      = 255;
    localparam int DEPTH            = 16;
    localparam int ADDR_W           = 4;
    localparam int PTR_W            = ADDR_W + 1;
    localparam int CNT_W            = 6;
    localparam int FILL_W           = 24;
    localparam int SYNC_LEN         = 2;
    localparam int ING_DEPTH        = 4;
    localparam int CSR_AW           = 3;

    // ****************************************
    // Register word indices and reset values
    // ****************************************
    localparam logic [CSR_AW-1:0] ADDR_FILL   = 3'h0;
    localparam logic [CSR_AW-1:0] ADDR_RSVD   = 3'h1;
    localparam logic [CSR_AW-1:0] ADDR_AFULL  = 3'h2;
    localparam logic [CSR_AW-1:0] ADDR_AEMPTY = 3'h3;
    localparam logic [CSR_AW-1:0] ADDR_CUT    = 3'h4;
    localparam logic [CSR_AW-1:0] ADDR_DROP   = 3'h5;
    localparam logic [CSR_AW-1:0] ADDR_INFILL = 3'h6;
    localparam logic [FILL_W-1:0] FILL_RST    = 24'h000000;
    localparam logic [FILL_W-1:0] AFULL_RST   = FILL_W'(DEPTH - 1);
    localparam logic [FILL_W-1:0] AEMPTY_RST  = 24'h000000;
    localparam logic [FILL_W-1:0] CUT_RST     = 24'h000000;
    localparam logic              DROP_RST    = 1'b0;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        MODE_DEFAULT = 2'b00,
        MODE_SF      = 2'b01,
        MODE_CUT     = 2'b10
    } mode_e;

    typedef struct packed {
        logic [DATA_W-1:0]    data;
        logic [CHANNEL_W-1:0] channel;
        logic [ERROR_W-1:0]   error;
        logic                 sop;
        logic                 eop;
    } beat_s;

    localparam int BEAT_W = $bits(beat_s);

    typedef struct packed {
        logic [CSR_AW-1:0] address;
        logic              read;
        logic              write;
        logic [31:0]       writedata;
    } csr_req_s;

    typedef struct packed {
        beat_s [DEPTH-1:0]               mem;
        logic [PTR_W-1:0]                wr_ptr;
        logic [PTR_W-1:0]                commit_ptr;
        logic [PTR_W-1:0]                rd_ptr;
        logic [SYNC_LEN-1:0][PTR_W-1:0]  wsync;
        logic [SYNC_LEN-1:0][PTR_W-1:0]  rsync;
        logic                            pkt_err;
        beat_s                           out_beat;
        logic                            out_valid;
        logic [FILL_W-1:0]               af_lvl;
        logic [FILL_W-1:0]               ae_lvl;
        logic [FILL_W-1:0]               cut_lvl;
        logic                            drop_en;
        logic [31:0]                     rdata;
        logic                            near_full;
        logic                            near_empty;
    } core_s;

endpackage

// ### rtl/stream_fifo.sv
// Streaming FIFO with ingress buffer, release modes and status registers
`timescale 1ns/1ps

// ****************************************
// Ingress buffer
// ****************************************
module stream_buf #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic      [W-1:0] out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [CW-1:0]       cnt;
        logic                rdy;
    } buf_s;

    buf_s s;
    buf_s next_s;
    logic push;
    logic pop;

    assign in_ready  = s.rdy;
    assign out_valid = (s.cnt != '0);
    assign out_data  = s.mem[s.rp];

    always_comb begin
        next_s = s;
        push   = in_valid && s.rdy;
        pop    = out_valid && out_ready;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp        = s.wp + AW'(1);
        end
        if (pop) begin
            next_s.rp = s.rp + AW'(1);
        end
        if (push && !pop) begin
            next_s.cnt = s.cnt + CW'(1);
        end else if (pop && !push) begin
            next_s.cnt = s.cnt - CW'(1);
        end
        next_s.rdy = (next_s.cnt < CW'(D));
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s     <= '0;
            s.rdy <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule

// ****************************************
// Streaming FIFO core
// ****************************************
module stream_fifo import sfifo_pkg::*; #(
    parameter bit USE_FILL     = 1'b1,
    parameter bit USE_SF       = 1'b0,
    parameter bit USE_NEAR     = 1'b1,
    parameter bit DUAL_VARIANT = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire beat_s       in_beat,
    input  wire logic        in_valid,
    output logic             in_ready,
    output beat_s            out_beat,
    output logic             out_valid,
    input  wire logic        out_ready,
    input  wire csr_req_s    csr_req,
    output logic [31:0]      csr_readdata,
    output logic             near_full,
    output logic             near_empty
);
    localparam bit NEAR_EN = USE_FILL && USE_NEAR && !DUAL_VARIANT;

    core_s            s;
    core_s            next_s;
    beat_s            buf_beat;
    logic             buf_valid;
    logic             buf_ready;
    logic             accept;
    logic             drop_now;
    logic             avail;
    logic             load;
    logic             committed;
    logic [PTR_W-1:0] wr_view;
    logic [PTR_W-1:0] rd_view;
    logic [PTR_W-1:0] stored;
    logic [PTR_W-1:0] in_cnt;
    logic [CNT_W-1:0] out_cnt;
    mode_e            mode;

    // ****************************************
    // Ingress buffer in the data path
    // ****************************************
    stream_buf #(
        .W (BEAT_W),
        .D (ING_DEPTH)
    ) u_ingress (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   (in_beat),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .out_data  (buf_beat),
        .out_valid (buf_valid),
        .out_ready (buf_ready)
    );

    assign out_beat     = s.out_beat;
    assign out_valid    = s.out_valid;
    assign csr_readdata = s.rdata;
    assign near_full    = s.near_full;
    assign near_empty   = s.near_empty;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_s = s;
        // Pointer views, delayed through a chain in the dual variant
        wr_view = DUAL_VARIANT ? s.wsync[SYNC_LEN-1] : s.wr_ptr;
        rd_view = DUAL_VARIANT ? s.rsync[SYNC_LEN-1] : s.rd_ptr;
        next_s.wsync = {s.wsync[SYNC_LEN-2:0], s.wr_ptr};
        next_s.rsync = {s.rsync[SYNC_LEN-2:0], s.rd_ptr};

        // Writer-side count excludes the output register
        in_cnt    = s.wr_ptr - rd_view;
        stored    = wr_view - s.rd_ptr;
        // Reader-side count includes the output register
        out_cnt   = CNT_W'(stored) + CNT_W'(s.out_valid);
        committed = (s.commit_ptr != s.rd_ptr);

        if (DUAL_VARIANT) begin
            mode = MODE_DEFAULT;
        end else if (USE_SF) begin
            mode = MODE_SF;
        end else if (s.cut_lvl != '0) begin
            mode = MODE_CUT;
        end else begin
            mode = MODE_DEFAULT;
        end

        case (mode)
            MODE_DEFAULT: avail = (stored != '0);
            MODE_SF:      avail = committed;
            MODE_CUT: begin
                avail = (stored != '0)
                     && ((FILL_W'(stored) >= s.cut_lvl) || committed);
            end
            default:      avail = 1'b0;
        endcase

        // Output pipeline register
        load = avail && (!s.out_valid || out_ready);
        if (load) begin
            next_s.out_beat  = s.mem[s.rd_ptr[ADDR_W-1:0]];
            next_s.out_valid = 1'b1;
            next_s.rd_ptr    = s.rd_ptr + PTR_W'(1);
        end else if (out_ready) begin
            next_s.out_valid = 1'b0;
        end

        // Write side, stalls the ingress buffer when full
        buf_ready = (in_cnt < PTR_W'(DEPTH));
        accept    = buf_valid && buf_ready;
        drop_now  = accept && (mode == MODE_SF) && s.drop_en && buf_beat.eop
                 && (s.pkt_err || (|buf_beat.error));
        if (drop_now) begin
            next_s.wr_ptr  = s.commit_ptr;
            next_s.pkt_err = 1'b0;
        end else if (accept) begin
            next_s.mem[s.wr_ptr[ADDR_W-1:0]] = buf_beat;
            next_s.wr_ptr = s.wr_ptr + PTR_W'(1);
            if (buf_beat.eop) begin
                next_s.commit_ptr = s.wr_ptr + PTR_W'(1);
                next_s.pkt_err    = 1'b0;
            end else begin
                next_s.pkt_err = s.pkt_err || (|buf_beat.error);
            end
        end

        // Threshold status
        next_s.near_full  = NEAR_EN && (FILL_W'(out_cnt) >= s.af_lvl);
        next_s.near_empty = NEAR_EN && (FILL_W'(out_cnt) <= s.ae_lvl);

        // Register port
        if (USE_FILL && csr_req.read) begin
            case (csr_req.address)
                ADDR_FILL:   next_s.rdata = 32'(FILL_W'(out_cnt));
                ADDR_INFILL: next_s.rdata = 32'(FILL_W'(in_cnt));
                ADDR_AFULL:  next_s.rdata = 32'(s.af_lvl);
                ADDR_AEMPTY: next_s.rdata = 32'(s.ae_lvl);
                ADDR_CUT:    next_s.rdata = 32'(s.cut_lvl);
                ADDR_DROP:   next_s.rdata = 32'(s.drop_en);
                default:     next_s.rdata = 32'h00000000;
            endcase
        end
        if (USE_FILL && csr_req.write) begin
            case (csr_req.address)
                ADDR_AFULL:  next_s.af_lvl  = csr_req.writedata[FILL_W-1:0];
                ADDR_AEMPTY: next_s.ae_lvl  = csr_req.writedata[FILL_W-1:0];
                ADDR_CUT:    next_s.cut_lvl = csr_req.writedata[FILL_W-1:0];
                ADDR_DROP:   next_s.drop_en = csr_req.writedata[0];
                default:     next_s.drop_en = s.drop_en;
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s            <= '0;
            s.af_lvl     <= AFULL_RST;
            s.ae_lvl     <= AEMPTY_RST;
            s.cut_lvl    <= CUT_RST;
            s.drop_en    <= DROP_RST;
            s.near_empty <= NEAR_EN;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence fill_read_s;
        csr_req.read && (csr_req.address == ADDR_FILL);
    endsequence

    sequence drop_eop_s;
        drop_now;
    endsequence

    sequence cut_ready_s;
        (mode == MODE_CUT) && !s.out_valid && (stored != '0)
            && (FILL_W'(stored) >= s.cut_lvl);
    endsequence

    valid_nonempty_a: assert property (
        $rose(s.out_valid) |-> ($past(stored) != '0))
        else $error("source valid rose with nothing stored");

    sf_packet_a: assert property (
        (mode == MODE_SF) && $rose(s.out_valid) |-> $past(committed))
        else $error("store-forward released before a full packet");

    drop_rewind_a: assert property (
        drop_eop_s |=> (s.wr_ptr == $past(s.commit_ptr)) && !s.pkt_err)
        else $error("errored packet not discarded");

    cut_release_a: assert property (
        cut_ready_s |=> s.out_valid)
        else $error("cut-through did not release at threshold");

    near_full_a: assert property (
        NEAR_EN |=> s.near_full == (FILL_W'($past(out_cnt)) >= $past(s.af_lvl)))
        else $error("near-full flag wrong");

    near_empty_a: assert property (
        NEAR_EN |=> s.near_empty == (FILL_W'($past(out_cnt)) <= $past(s.ae_lvl)))
        else $error("near-empty flag wrong");

    fill_read_a: assert property (
        fill_read_s |=> s.rdata == {8'h00, FILL_W'($past(out_cnt))})
        else $error("fill register read wrong");

    full_block_a: assert property (
        (in_cnt == PTR_W'(DEPTH)) |-> !accept ##1 (in_cnt <= PTR_W'(DEPTH)))
        else $error("write accepted while full");

    reset_empty_a: assert property (disable iff (1'b0)
        !rst_n |=> !s.out_valid && (out_cnt == '0) && (s.af_lvl == AFULL_RST))
        else $error("reset did not empty the buffer");

    sequence out_stall_s;
        s.out_valid && !out_ready;
    endsequence

    out_hold_a: assert property (
        out_stall_s |=> s.out_valid && $stable(s.out_beat))
        else $error("source word changed before it was taken");

    sequence ptr_sync_s;
        (wr_view == $past(s.wr_ptr, SYNC_LEN)) && (rd_view == $past(s.rd_ptr, SYNC_LEN));
    endsequence

    ptr_lag_a: assert property (
        DUAL_VARIANT |-> ##2 ptr_sync_s)
        else $error("pointer view not delayed by the chain");

    in_fill_limit_a: assert property (
        in_cnt <= PTR_W'(DEPTH))
        else $error("input-side count above depth");

    fill_bound_a: assert property (
        out_cnt <= CNT_W'(DEPTH + 1))
        else $error("output-side count above capacity");

    near_off_a: assert property (
        !NEAR_EN |-> !s.near_full && !s.near_empty)
        else $error("near flags active while disabled");

    sequence empty_idle_s;
        !s.out_valid && (stored == '0);
    endsequence

    empty_quiet_a: assert property (
        empty_idle_s |=> !s.out_valid)
        else $error("source valid raised while empty");

    rdata_upper_a: assert property (
        csr_req.read |=> (s.rdata[31:24] == 8'h00))
        else $error("unused register bits not zero");

    sequence afull_write_s;
        USE_FILL && csr_req.write && (csr_req.address == ADDR_AFULL);
    endsequence

    afull_write_a: assert property (
        afull_write_s |=> s.af_lvl == FILL_W'($past(csr_req.writedata)))
        else $error("near-full threshold write lost");

    sequence eop_write_s;
        accept && !drop_now && buf_beat.eop;
    endsequence

    eop_commit_a: assert property (
        eop_write_s |=> (s.commit_ptr == s.wr_ptr))
        else $error("packet end not committed");
endmodule

// ### tb/stream_partner.sv
// Downstream sink model: random back-pressure, records every word taken
`timescale 1ns/1ps

module stream_partner import sfifo_pkg::*; (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire beat_s      out_beat,
    input  wire logic       out_valid,
    input  wire logic [7:0] stall,
    output logic            out_ready
);
    beat_s got_q[$];

    initial out_ready = 1'b0;

    // ****************************************
    // Capture and ready
    // ****************************************
    always @(posedge clk) begin
        if (rst_n && out_valid && out_ready) begin
            got_q.push_back(out_beat);
        end
        out_ready <= rst_n && ($urandom_range(99) >= stall);
    end
endmodule

// ### tb/tb_stream_fifo.sv
// Self-checking bench for the streaming FIFO
`timescale 1ns/1ps

module tb_stream_fifo import sfifo_pkg::*; ;
    logic        clk;
    logic        rst_n;
    logic        in_valid;
    logic        sel_sf;
    logic        sel_dc;
    logic        rdy_c;
    logic        ov_c;
    logic        nf_c;
    logic        ne_c;
    logic [31:0] rd_c;
    beat_s       ob_c;
    logic        out_ready;
    logic        rdy_d;
    logic        rdy_s;
    logic        ov_d;
    logic        ov_s;
    logic        near_full;
    logic        near_empty;
    logic [7:0]  stall;
    logic [31:0] rd_d;
    logic [31:0] rd_s;
    beat_s       in_beat;
    beat_s       ob_d;
    beat_s       ob_s;
    csr_req_s    csr_req;
    beat_s       exp_q[$];
    int          failures;
    int          comparisons;
    logic [31:0] reg_exp [8] = '{32'h0, 32'h0, 32'(DEPTH - 1), 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    wire logic        ov  = sel_dc ? ov_c : sel_sf ? ov_s : ov_d;
    wire logic        rdy = sel_dc ? rdy_c : sel_sf ? rdy_s : rdy_d;
    wire logic [31:0] rd  = sel_dc ? rd_c : sel_sf ? rd_s : rd_d;
    wire beat_s       ob  = sel_dc ? ob_c : sel_sf ? ob_s : ob_d;

    stream_fifo dut_u (
        .clk(clk), .rst_n(rst_n), .in_beat(in_beat), .in_valid(in_valid && !sel_sf && !sel_dc),
        .in_ready(rdy_d), .out_beat(ob_d), .out_valid(ov_d), .out_ready(out_ready),
        .csr_req(csr_req), .csr_readdata(rd_d), .near_full(near_full), .near_empty(near_empty));

    stream_fifo #(.USE_SF(1'b1)) dut_sf (
        .clk(clk), .rst_n(rst_n), .in_beat(in_beat), .in_valid(in_valid && sel_sf),
        .in_ready(rdy_s), .out_beat(ob_s), .out_valid(ov_s), .out_ready(out_ready),
        .csr_req(csr_req), .csr_readdata(rd_s), .near_full(), .near_empty());

    stream_fifo #(.DUAL_VARIANT(1'b1)) dut_c (
        .clk(clk), .rst_n(rst_n), .in_beat(in_beat), .in_valid(in_valid && sel_dc),
        .in_ready(rdy_c), .out_beat(ob_c), .out_valid(ov_c), .out_ready(out_ready),
        .csr_req(csr_req), .csr_readdata(rd_c), .near_full(nf_c), .near_empty(ne_c));

    stream_partner sink_u (.clk(clk), .rst_n(rst_n), .out_beat(ob), .out_valid(ov),
        .stall(stall), .out_ready(out_ready));

    always #5 clk = ~clk;

    // ****************************************
    // Helpers
    // ****************************************
    task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_beat(input string what, input beat_s exp, input beat_s got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        if (failures == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic csr(input logic [2:0] a, input logic wr, input logic [31:0] d);
        csr_req = '{address: a, read: !wr, write: wr, writedata: d};
        tick(1);
        csr_req = '0;
        tick(1);
    endtask

    function automatic beat_s rnd_beat(input logic sop, input logic eop, input logic err);
        beat_s b;
        b.data = $urandom;
        b.channel = CHANNEL_W'($urandom_range(MAX_CHANNEL));
        b.error = err;
        b.sop = sop;
        b.eop = eop;
        return b;
    endfunction

    task automatic send(input beat_s b, input logic keep);
        int n;
        n = 0;
        if ($urandom_range(3) == 0) begin
            in_valid = 1'b0;
            tick(1);
        end
        in_beat = b;
        in_valid = 1'b1;
        while (rdy !== 1'b1 && n < 300) begin
            tick(1);
            n++;
        end
        if (n == 300) failures++;
        tick(1);
        if (keep) exp_q.push_back(b);
    endtask

    task automatic idle();
        in_valid = 1'b0;
        in_beat = ~in_beat;
    endtask

    task automatic pkt(input int len, input int errpos, input logic keep);
        for (int i = 0; i < len; i++) send(rnd_beat(i == 0, i == len - 1, i == errpos), keep);
        idle();
    endtask

    task automatic check_all();
        int n;
        n = 0;
        while (sink_u.got_q.size() < exp_q.size() && n < 2000) begin
            tick(1);
            n++;
        end
        tick(4);
        cmp_word("word count", 32'(exp_q.size()), 32'(sink_u.got_q.size()));
        foreach (exp_q[i]) begin
            if (i < sink_u.got_q.size()) cmp_beat("word", exp_q[i], sink_u.got_q[i]);
        end
        exp_q.delete();
        sink_u.got_q.delete();
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #500000;
        failures++;
        results();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        in_valid = 1'b0;
        in_beat = '0;
        sel_sf = 1'b0;
        sel_dc = 1'b0;
        stall = 8'h00;
        csr_req = '0;
        failures = 0;
        comparisons = 0;
        void'($urandom(32'h29F3));
        tick(16);
        rst_n = 1'b1;
        tick(1);
        cmp_word("out_valid", 32'h0, ov);
        cmp_word("near_empty", 32'h1, near_empty);
        cmp_word("near_full", 32'h0, near_full);
        csr(3'h0, 1'b1, 32'hFFFFFFFF);
        csr(3'h1, 1'b1, 32'hFFFFFFFF);
        foreach (reg_exp[i]) begin
            csr(3'(i), 1'b0, 32'h0);
            cmp_word("register", reg_exp[i], rd);
        end
        csr(3'h2, 1'b1, 32'hABCD1234);
        csr(3'h2, 1'b0, 32'h0);
        cmp_word("near-full level", 32'h00CD1234, rd);
        stall = 8'h1E;
        repeat (8) pkt($urandom_range(1, 6), -1, 1'b1);
        check_all();
        csr(3'h2, 1'b1, 32'h11);
        csr(3'h3, 1'b1, 32'h11);
        stall = 8'h64;
        tick(2);
        pkt(DEPTH + 1 + ING_DEPTH, -1, 1'b1);
        tick(3);
        cmp_word("sink ready", 32'h0, rdy);
        csr(3'h0, 1'b0, 32'h0);
        cmp_word("fill", 32'(DEPTH + 1), rd);
        csr(3'h6, 1'b0, 32'h0);
        cmp_word("input fill", 32'(DEPTH), rd);
        cmp_word("near_full", 32'h1, near_full);
        cmp_word("near_empty", 32'h1, near_empty);
        csr(3'h2, 1'b1, 32'h12);
        csr(3'h3, 1'b1, 32'h10);
        tick(2);
        cmp_word("near_full", 32'h0, near_full);
        cmp_word("near_empty", 32'h0, near_empty);
        stall = 8'h00;
        check_all();
        csr(3'h0, 1'b0, 32'h0);
        cmp_word("fill", 32'h0, rd);
        cmp_word("near_empty", 32'h1, near_empty);
        csr(3'h4, 1'b1, 32'h3);
        send(rnd_beat(1'b1, 1'b0, 1'b0), 1'b1);
        send(rnd_beat(1'b0, 1'b0, 1'b0), 1'b1);
        idle();
        tick(8);
        cmp_word("early words", 32'h0, 32'(sink_u.got_q.size()));
        send(rnd_beat(1'b0, 1'b0, 1'b0), 1'b1);
        idle();
        tick(8);
        cmp_word("released", 32'h1, 32'(sink_u.got_q.size() != 0));
        pkt(1, -1, 1'b1);
        check_all();
        csr(3'h4, 1'b1, 32'h0);
        sel_sf = 1'b1;
        stall = 8'h1E;
        send(rnd_beat(1'b1, 1'b0, 1'b0), 1'b1);
        send(rnd_beat(1'b0, 1'b0, 1'b0), 1'b1);
        idle();
        tick(10);
        cmp_word("early words", 32'h0, 32'(sink_u.got_q.size()));
        pkt(1, -1, 1'b1);
        check_all();
        csr(3'h5, 1'b1, 32'h1);
        pkt(4, 2, 1'b0);
        pkt(3, -1, 1'b1);
        pkt(2, 1, 1'b0);
        pkt(2, -1, 1'b1);
        check_all();
        sel_sf = 1'b0;
        sel_dc = 1'b1;
        stall = 8'h64;
        tick(2);
        pkt(3, -1, 1'b1);
        tick(8);
        csr(3'h0, 1'b0, 32'h0);
        cmp_word("output fill", 32'h3, rd);
        csr(3'h6, 1'b0, 32'h0);
        cmp_word("input fill", 32'h2, rd);
        cmp_word("dual near flags", 32'h0, 32'({nf_c, ne_c}));
        stall = 8'h00;
        check_all();
        sel_dc = 1'b0;
        stall = 8'h64;
        tick(2);
        pkt(5, -1, 1'b0);
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(1);
        cmp_word("out_valid", 32'h0, ov);
        csr(3'h0, 1'b0, 32'h0);
        cmp_word("fill", 32'h0, rd);
        results();
    end
endmodule
